/* File: prs_sequencer.sv */
module prs_sequencer
#(
	parameter int PLL_LOCK_BASE = prs_pkg::PLL_LOCK_CYCLES
)
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	// Board pins
	input  wire logic        POWER_ON_RESET_IN_N,
	input  wire logic        CONFIG_MODE_STRAP,
	input  wire logic        CONFIG_SOURCE_STRAP,
	input  wire logic        HOST_SYNC_STRAP,
	input  wire logic        HOST_WIDE_STRAP,
	input  wire logic [3:0]  CHIP_SELECT_ID_STRAPS,
	input  wire logic [2:0]  BOOT_MODE_STRAPS,
	input  wire logic        WATCHDOG_ENABLE_STRAP,
	input  wire logic [1:0]  CLOCK_MODE_STRAPS,
	// Open-drain reset lines
	output logic             HARD_RESET_LINE_OUT,
	output logic             HARD_RESET_LINE_OE,
	output logic             SOFT_RESET_LINE_OUT,
	output logic             SOFT_RESET_LINE_OE,
	// Configuration word sources
	input  wire logic        HOST_CFG_VALID,
	input  wire logic [31:0] HOST_CFG_WORD,
	input  wire logic        BUS_CFG_VALID,
	input  wire logic [31:0] BUS_CFG_WORD,
	output logic             BUS_CFG_FETCH_REQ,
	// Clocking configuration
	input  wire logic [3:0]  REFERENCE_DIVISION_FACTOR,
	input  wire logic [3:0]  CORE_CLOCK_RATIO,
	input  wire logic [1:0]  MC_TICK_SELECT,
	// Status
	output logic             INTERNAL_POR_N,
	output logic             SYSTEM_PLL_LOCK,
	output logic             POR_PULSE_SHORT,
	output logic [31:0]      CONFIG_WORD,
	output logic             CONFIG_WORD_DEFAULTED,
	// Latched straps
	output logic             LATCHED_CONFIG_MODE,
	output logic             LATCHED_CONFIG_SOURCE,
	output logic             LATCHED_HOST_SYNC,
	output logic             LATCHED_HOST_WIDE,
	output logic [3:0]       LATCHED_CHIP_ID,
	output logic [2:0]       LATCHED_BOOT_MODE,
	output logic             LATCHED_WATCHDOG_ENABLE,
	output logic [1:0]       LATCHED_CLOCK_MODE,
	// Memory controller tick plan
	output logic [3:0]       TICK_DENOM,
	output logic [3:0]       TICK2_POS,
	output logic [3:0]       TICK3_POS,
	output logic [3:0]       TICK4_POS,
	output logic [3:0]       USER_MACHINE_TICK_POS,
	output logic [3:0]       SDRAM_MACHINE_TICK_POS,
	output logic             RATIO_UNSUPPORTED
);

	// ********************************************************************
	// Pin synchronisers
	// ********************************************************************
	logic [14:0] pin_meta_r;
	logic [14:0] pin_sync_r;
	logic [14:0] pin_raw;
	logic        por_in_active;
	logic [13:0] strap_now;

	assign pin_raw = {POWER_ON_RESET_IN_N, CLOCK_MODE_STRAPS, WATCHDOG_ENABLE_STRAP,
		BOOT_MODE_STRAPS, CHIP_SELECT_ID_STRAPS, HOST_WIDE_STRAP, HOST_SYNC_STRAP,
		CONFIG_SOURCE_STRAP, CONFIG_MODE_STRAP};
	assign por_in_active = ~pin_sync_r[14];
	assign strap_now = pin_sync_r[13:0];

	// ********************************************************************
	// Reset sequencer
	// ********************************************************************
	// A zero division factor would stall the lock timer, so it counts as one.
	logic [19:0]          lock_cycles;
	logic [3:0]           div_eff;
	prs_pkg::prs_state_t  state_r, state_nxt;
	logic [19:0]          cnt_r, cnt_nxt;
	logic [4:0]           por_len_r, por_len_nxt;
	logic                 short_r, short_nxt;
	logic [13:0]          strap_r, strap_nxt;
	logic                 int_por_n_r, int_por_n_nxt;
	logic                 lock_r, lock_nxt;
	logic                 hard_drv_r, hard_drv_nxt;
	logic                 soft_drv_r, soft_drv_nxt;
	logic                 fetch_r, fetch_nxt;
	logic [31:0]          cfg_r, cfg_nxt;
	logic                 cfg_seen_r, cfg_seen_nxt;
	logic                 cfg_dflt_r, cfg_dflt_nxt;
	logic                 cfg_open;
	logic                 cfg_valid;
	logic [31:0]          cfg_word;

	assign div_eff = (REFERENCE_DIVISION_FACTOR == 4'h0) ? 4'h1 : REFERENCE_DIVISION_FACTOR;
	assign lock_cycles = 20'(PLL_LOCK_BASE) * 20'(div_eff);

	// The configuration window runs from internal reset release to hard reset release.
	assign cfg_open = (state_r == prs_pkg::PRS_PLL_WAIT) || (state_r == prs_pkg::PRS_HARD_WAIT);
	// Source strap high selects the system bus, low the slave host interface.
	assign cfg_valid = strap_r[prs_pkg::S_CFG_SOURCE] ? BUS_CFG_VALID : HOST_CFG_VALID;
	assign cfg_word  = strap_r[prs_pkg::S_CFG_SOURCE] ? BUS_CFG_WORD : HOST_CFG_WORD;

	always_comb
	begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r + 20'h00001;
		por_len_nxt   = por_len_r;
		short_nxt     = short_r;
		strap_nxt     = strap_r;
		int_por_n_nxt = int_por_n_r;
		lock_nxt      = lock_r;
		hard_drv_nxt  = hard_drv_r;
		soft_drv_nxt  = soft_drv_r | hard_drv_r;
		fetch_nxt     = 1'b0;
		cfg_nxt       = cfg_r;
		cfg_seen_nxt  = cfg_seen_r;
		cfg_dflt_nxt  = cfg_dflt_r;
		if (cfg_open && cfg_valid && !cfg_seen_r)
		begin
			cfg_nxt      = cfg_word;
			cfg_seen_nxt = 1'b1;
		end
		if (por_in_active)
		begin
			// The whole sequence restarts on any assertion of the input.
			state_nxt     = prs_pkg::PRS_POR_HELD;
			cnt_nxt       = 20'h00000;
			int_por_n_nxt = 1'b0;
			lock_nxt      = 1'b0;
			hard_drv_nxt  = 1'b1;
			soft_drv_nxt  = 1'b1;
			cfg_nxt       = prs_pkg::CFG_WORD_RESET;
			cfg_seen_nxt  = 1'b0;
			cfg_dflt_nxt  = 1'b0;
			if (state_r != prs_pkg::PRS_POR_HELD)
				por_len_nxt = 5'h01;
			else if (por_len_r != 5'h1F)
				por_len_nxt = por_len_r + 5'h01;
		end
		else
		begin
			case (state_r)
				prs_pkg::PRS_POR_HELD:
				begin
					strap_nxt = strap_now;
					// Too short a pulse is still honoured but flagged.
					short_nxt = (por_len_r < 5'(prs_pkg::POR_MIN_CYCLES));
					state_nxt = prs_pkg::PRS_INT_POR;
					cnt_nxt   = 20'h00001;
				end
				prs_pkg::PRS_INT_POR:
				begin
					if (cnt_r == 20'(prs_pkg::INT_POR_CYCLES - 1))
					begin
						int_por_n_nxt = 1'b1;
						state_nxt     = prs_pkg::PRS_PLL_WAIT;
						cnt_nxt       = 20'h00000;
						fetch_nxt     = strap_r[prs_pkg::S_CFG_SOURCE]
							& strap_r[prs_pkg::S_CFG_MODE];
					end
				end
				prs_pkg::PRS_PLL_WAIT:
				begin
					if (cnt_r == lock_cycles - 20'h00001)
					begin
						lock_nxt  = 1'b1;
						state_nxt = prs_pkg::PRS_HARD_WAIT;
						cnt_nxt   = 20'h00000;
					end
				end
				prs_pkg::PRS_HARD_WAIT:
				begin
					if (cnt_r == 20'(prs_pkg::HARD_RELEASE_CYCLES - 1))
					begin
						hard_drv_nxt = 1'b0;
						state_nxt    = prs_pkg::PRS_SOFT_WAIT;
						if (!(cfg_valid || cfg_seen_r))
						begin
							cfg_nxt      = prs_pkg::CFG_WORD_DEFAULT;
							cfg_dflt_nxt = 1'b1;
						end
					end
				end
				prs_pkg::PRS_SOFT_WAIT:
				begin
					if (cnt_r == 20'(prs_pkg::SOFT_RELEASE_CYCLES - 1))
					begin
						soft_drv_nxt = 1'b0;
						state_nxt    = prs_pkg::PRS_RUN;
						cnt_nxt      = 20'h00000;
					end
				end
				prs_pkg::PRS_RUN: cnt_nxt = cnt_r;
				default:          state_nxt = prs_pkg::PRS_POR_HELD;
			endcase
		end
	end

	// Every output below but the constant ones leaves a flip-flop clocked on the rising edge.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			pin_meta_r  <= 15'h0000;
			pin_sync_r  <= 15'h0000;
			state_r     <= prs_pkg::PRS_POR_HELD;
			cnt_r       <= 20'h00000;
			por_len_r   <= 5'h00;
			short_r     <= 1'b0;
			strap_r     <= prs_pkg::STRAP_RESET;
			int_por_n_r <= 1'b0;
			lock_r      <= 1'b0;
			hard_drv_r  <= 1'b1;
			soft_drv_r  <= 1'b1;
			fetch_r     <= 1'b0;
			cfg_r       <= prs_pkg::CFG_WORD_RESET;
			cfg_seen_r  <= 1'b0;
			cfg_dflt_r  <= 1'b0;
		end
		else
		begin
			pin_meta_r  <= pin_raw;
			pin_sync_r  <= pin_meta_r;
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			por_len_r   <= por_len_nxt;
			short_r     <= short_nxt;
			strap_r     <= strap_nxt;
			int_por_n_r <= int_por_n_nxt;
			lock_r      <= lock_nxt;
			hard_drv_r  <= hard_drv_nxt;
			soft_drv_r  <= soft_drv_nxt;
			fetch_r     <= fetch_nxt;
			cfg_r       <= cfg_nxt;
			cfg_seen_r  <= cfg_seen_nxt;
			cfg_dflt_r  <= cfg_dflt_nxt;
		end
	end

	// ********************************************************************
	// Memory controller tick plan
	// ********************************************************************
	// The block has only the rising-edge clock, so it publishes tick positions
	// for the memory controller's multiphase clocking rather than the ticks.
	logic [3:0] den_r, den_nxt;
	logic [3:0] t2_r, t2_nxt;
	logic [3:0] t4_r, t4_nxt;
	logic [3:0] usr_r, usr_nxt;
	logic       bad_r, bad_nxt;

	always_comb
	begin
		den_nxt = prs_pkg::DEN_QUARTER;
		t2_nxt  = prs_pkg::T2_QUARTER;
		t4_nxt  = prs_pkg::T4_QUARTER;
		bad_nxt = 1'b0;
		case (CORE_CLOCK_RATIO)
			prs_pkg::RATIO_4, prs_pkg::RATIO_6, prs_pkg::RATIO_8, prs_pkg::RATIO_10:
			begin
				bad_nxt = 1'b0;
			end
			prs_pkg::RATIO_3:
			begin
				den_nxt = prs_pkg::DEN_SIXTH;
				t2_nxt  = prs_pkg::T2_SIXTH;
				t4_nxt  = prs_pkg::T4_SIXTH;
			end
			prs_pkg::RATIO_5:
			begin
				den_nxt = prs_pkg::DEN_TENTH;
				t2_nxt  = prs_pkg::T2_TENTH;
				t4_nxt  = prs_pkg::T4_TENTH;
			end
			default: bad_nxt = 1'b1;
		endcase
		case (MC_TICK_SELECT)
			2'h0:    usr_nxt = prs_pkg::TICK_ZERO;
			2'h1:    usr_nxt = t2_nxt;
			2'h2:    usr_nxt = den_nxt >> 1;
			default: usr_nxt = t4_nxt;
		endcase
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			den_r <= prs_pkg::DEN_QUARTER;
			t2_r  <= prs_pkg::T2_QUARTER;
			t4_r  <= prs_pkg::T4_QUARTER;
			usr_r <= prs_pkg::TICK_ZERO;
			bad_r <= 1'b0;
		end
		else
		begin
			den_r <= den_nxt;
			t2_r  <= t2_nxt;
			t4_r  <= t4_nxt;
			usr_r <= usr_nxt;
			bad_r <= bad_nxt;
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign HARD_RESET_LINE_OUT     = 1'b0;
	assign HARD_RESET_LINE_OE      = hard_drv_r;
	assign SOFT_RESET_LINE_OUT     = 1'b0;
	assign SOFT_RESET_LINE_OE      = soft_drv_r;
	assign BUS_CFG_FETCH_REQ       = fetch_r;
	assign INTERNAL_POR_N          = int_por_n_r;
	assign SYSTEM_PLL_LOCK         = lock_r;
	assign POR_PULSE_SHORT         = short_r;
	assign CONFIG_WORD             = cfg_r;
	assign CONFIG_WORD_DEFAULTED   = cfg_dflt_r;
	assign LATCHED_CONFIG_MODE     = strap_r[prs_pkg::S_CFG_MODE];
	assign LATCHED_CONFIG_SOURCE   = strap_r[prs_pkg::S_CFG_SOURCE];
	assign LATCHED_HOST_SYNC       = strap_r[prs_pkg::S_HOST_SYNC];
	assign LATCHED_HOST_WIDE       = strap_r[prs_pkg::S_HOST_WIDE];
	assign LATCHED_CHIP_ID         = strap_r[prs_pkg::S_CHIP_ID_LO +: 4];
	assign LATCHED_BOOT_MODE       = strap_r[prs_pkg::S_BOOT_LO +: 3];
	assign LATCHED_WATCHDOG_ENABLE = strap_r[prs_pkg::S_WDOG];
	assign LATCHED_CLOCK_MODE      = strap_r[prs_pkg::S_CLK_MODE_LO +: 2];
	assign TICK_DENOM              = den_r;
	assign TICK2_POS               = t2_r;
	assign TICK3_POS               = den_r >> 1;
	assign TICK4_POS               = t4_r;
	assign USER_MACHINE_TICK_POS   = usr_r;
	assign SDRAM_MACHINE_TICK_POS  = prs_pkg::TICK_ZERO;
	assign RATIO_UNSUPPORTED       = bad_r;

endmodule

/* File: prs_pkg.sv */
package prs_pkg;

	// ********************************************************************
	// Timing counts, in input-clock cycles
	// ********************************************************************
	localparam int POR_MIN_CYCLES     = 16;
	localparam int INT_POR_CYCLES     = 1024;
	localparam int PLL_LOCK_CYCLES    = 6400;
	localparam int HARD_RELEASE_CYCLES = 512;
	localparam int SOFT_RELEASE_CYCLES = 515;

	// ********************************************************************
	// Strap vector layout
	// ********************************************************************
	localparam int STRAP_W        = 14;
	localparam int S_CFG_MODE     = 0;
	localparam int S_CFG_SOURCE   = 1;
	localparam int S_HOST_SYNC    = 2;
	localparam int S_HOST_WIDE    = 3;
	localparam int S_CHIP_ID_LO   = 4;
	localparam int S_BOOT_LO      = 8;
	localparam int S_WDOG         = 11;
	localparam int S_CLK_MODE_LO  = 12;
	localparam logic [13:0] STRAP_RESET = 14'h0000;

	// ********************************************************************
	// Configuration word
	// ********************************************************************
	localparam logic [31:0] CFG_WORD_RESET   = 32'h00000000;
	// Built-in default word; the value is arbitrary.
	localparam logic [31:0] CFG_WORD_DEFAULT = 32'h0000A5A5;

	// ********************************************************************
	// Tick positions, as numerator over denominator of one cycle
	// ********************************************************************
	localparam logic [3:0] RATIO_3      = 4'h3;
	localparam logic [3:0] RATIO_4      = 4'h4;
	localparam logic [3:0] RATIO_5      = 4'h5;
	localparam logic [3:0] RATIO_6      = 4'h6;
	localparam logic [3:0] RATIO_8      = 4'h8;
	localparam logic [3:0] RATIO_10     = 4'hA;
	localparam logic [3:0] DEN_QUARTER  = 4'h4;
	localparam logic [3:0] DEN_SIXTH    = 4'h6;
	localparam logic [3:0] DEN_TENTH    = 4'hA;
	localparam logic [3:0] T2_QUARTER   = 4'h1;
	localparam logic [3:0] T4_QUARTER   = 4'h3;
	localparam logic [3:0] T2_SIXTH     = 4'h1;
	localparam logic [3:0] T4_SIXTH     = 4'h4;
	localparam logic [3:0] T2_TENTH     = 4'h2;
	localparam logic [3:0] T4_TENTH     = 4'h7;
	localparam logic [3:0] TICK_ZERO    = 4'h0;

	// ********************************************************************
	// Sequencer states
	// ********************************************************************
	typedef enum logic [2:0]
	{
		PRS_POR_HELD,
		PRS_INT_POR,
		PRS_PLL_WAIT,
		PRS_HARD_WAIT,
		PRS_SOFT_WAIT,
		PRS_RUN
	} prs_state_t;

endpackage

/* File: prs_assertions.sv */
module prs_assertions
#(
	parameter int PLL_LOCK_BASE = prs_pkg::PLL_LOCK_CYCLES
)
(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RESET_N,
	// Pin inputs
	input wire logic        POWER_ON_RESET_IN_N,
	input wire logic [3:0]  REFERENCE_DIVISION_FACTOR,
	input wire logic [3:0]  CORE_CLOCK_RATIO,
	// Sequencer outputs
	input wire logic        HARD_RESET_LINE_OE,
	input wire logic        SOFT_RESET_LINE_OE,
	input wire logic        INTERNAL_POR_N,
	input wire logic        SYSTEM_PLL_LOCK,
	input wire logic        BUS_CFG_FETCH_REQ,
	input wire logic        LATCHED_CONFIG_MODE,
	input wire logic        LATCHED_CONFIG_SOURCE,
	input wire logic [31:0] CONFIG_WORD,
	input wire logic        CONFIG_WORD_DEFAULTED,
	input wire logic [3:0]  TICK_DENOM,
	input wire logic [3:0]  TICK2_POS,
	input wire logic [3:0]  TICK3_POS,
	input wire logic [3:0]  TICK4_POS,
	input wire logic [3:0]  SDRAM_MACHINE_TICK_POS
);
	// ****************************************************************
	// Level age counters
	// ****************************************************************
	// The release counts exceed any delay operand, so ages are counted here.
	logic [15:0] pin_cnt_r;
	logic [15:0] pin_cnt_nxt;
	logic [15:0] ipor_cnt_r;
	logic [15:0] ipor_cnt_nxt;
	logic [15:0] lock_cnt_r;
	logic [15:0] lock_cnt_nxt;
	logic [15:0] lock_due;

	always_comb
	begin
		pin_cnt_nxt  = POWER_ON_RESET_IN_N ? pin_cnt_r + 16'h0001 : 16'h0000;
		ipor_cnt_nxt = INTERNAL_POR_N ? ipor_cnt_r + 16'h0001 : 16'h0000;
		lock_cnt_nxt = SYSTEM_PLL_LOCK ? lock_cnt_r + 16'h0001 : 16'h0000;
		lock_due     = 16'(PLL_LOCK_BASE) * ((REFERENCE_DIVISION_FACTOR == 4'h0) ?
			16'h0001 : 16'(REFERENCE_DIVISION_FACTOR));
	end

	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			pin_cnt_r  <= 16'h0000;
			ipor_cnt_r <= 16'h0000;
			lock_cnt_r <= 16'h0000;
		end
		else
		begin
			pin_cnt_r  <= pin_cnt_nxt;
			ipor_cnt_r <= ipor_cnt_nxt;
			lock_cnt_r <= lock_cnt_nxt;
		end
	end

	// ****************************************************************
	// Properties
	// ****************************************************************
	ipor_delay_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		$rose(INTERNAL_POR_N) |-> pin_cnt_r == 16'h0402)
		else $error("internal reset release off count");
	lock_delay_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		$rose(SYSTEM_PLL_LOCK) |-> ipor_cnt_r == lock_due)
		else $error("lock off count");
	hard_release_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		$fell(HARD_RESET_LINE_OE) |-> lock_cnt_r == 16'h0200)
		else $error("hard release off count");
	hard_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		SYSTEM_PLL_LOCK && lock_cnt_r < 16'h0200 |-> HARD_RESET_LINE_OE)
		else $error("hard line released early");
	soft_release_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		$fell(SOFT_RESET_LINE_OE) |-> lock_cnt_r == 16'h0203)
		else $error("soft release off count");
	soft_follows_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		HARD_RESET_LINE_OE |-> SOFT_RESET_LINE_OE)
		else $error("soft line free while hard driven");
	fetch_master_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		BUS_CFG_FETCH_REQ |-> $rose(INTERNAL_POR_N) && LATCHED_CONFIG_MODE
		&& LATCHED_CONFIG_SOURCE) else $error("fetch out of place");
	default_word_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		$rose(CONFIG_WORD_DEFAULTED) |-> $fell(HARD_RESET_LINE_OE)
		&& CONFIG_WORD == prs_pkg::CFG_WORD_DEFAULT) else $error("default word wrong");
	tick_half_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(TICK_DENOM == 4'h4 && TICK3_POS == 4'h2) || (TICK_DENOM == 4'h6 && TICK3_POS == 4'h3)
		|| (TICK_DENOM == 4'hA && TICK3_POS == 4'h5)) else $error("third tick not at half");
	ratio_sixth_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		$past(RESET_N) && $past(CORE_CLOCK_RATIO) == 4'h3 |-> TICK_DENOM == 4'h6
		&& TICK2_POS == 4'h1 && TICK4_POS == 4'h4) else $error("sixth tick plan wrong");
	ratio_tenth_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		$past(RESET_N) && $past(CORE_CLOCK_RATIO) == 4'h5 |-> TICK_DENOM == 4'hA
		&& TICK2_POS == 4'h2 && TICK4_POS == 4'h7) else $error("tenth tick plan wrong");
	sdram_rise_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		SDRAM_MACHINE_TICK_POS == 4'h0) else $error("sdram tick not at rise");
endmodule

bind prs_sequencer prs_assertions #(.PLL_LOCK_BASE(PLL_LOCK_BASE)) u_prs_assertions
(
	.CLK, .RESET_N, .POWER_ON_RESET_IN_N, .REFERENCE_DIVISION_FACTOR,
	.HARD_RESET_LINE_OE, .SOFT_RESET_LINE_OE, .INTERNAL_POR_N, .SYSTEM_PLL_LOCK,
	.BUS_CFG_FETCH_REQ, .LATCHED_CONFIG_MODE, .LATCHED_CONFIG_SOURCE, .CONFIG_WORD,
	.CONFIG_WORD_DEFAULTED, .TICK_DENOM, .TICK3_POS, .SDRAM_MACHINE_TICK_POS,
	.CORE_CLOCK_RATIO, .TICK2_POS, .TICK4_POS
);

/* File: prs_partner.sv */
module prs_partner
(
	// Clock
	input  wire logic        CLK,
	// Request from the device
	input  wire logic        BUS_CFG_FETCH_REQ,
	// Board side
	output logic             POR_N,
	output logic [13:0]      STRAPS,
	output logic             HOST_VALID,
	output logic [31:0]      HOST_WORD,
	output logic             BUS_VALID,
	output logic [31:0]      BUS_WORD
);
	timeunit 1ns;
	timeprecision 1ps;

	int          bus_delay = 0;
	logic [31:0] bus_word  = 32'h0;

	initial
	begin
		POR_N      = 1'b0;
		STRAPS     = 14'h0000;
		HOST_VALID = 1'b0;
		HOST_WORD  = 32'h0;
		BUS_VALID  = 1'b0;
		BUS_WORD   = 32'h0;
	end

	// Straps flip once their short hold is over, so a late latch shows up.
	task automatic por_pulse(input int hold, input logic [13:0] s);
		POR_N  <= 1'b0;
		STRAPS <= s;
		repeat (hold) @(posedge CLK);
		POR_N <= 1'b1;
		repeat (4) @(posedge CLK);
		STRAPS <= ~s;
	endtask

	task automatic send_host(input logic [31:0] w);
		HOST_VALID <= 1'b1;
		HOST_WORD  <= w;
		@(posedge CLK);
		HOST_VALID <= 1'b0;
		HOST_WORD  <= ~w;
		@(posedge CLK);
	endtask

	always @(posedge CLK)
	begin
		if (BUS_CFG_FETCH_REQ)
		begin
			repeat (bus_delay) @(posedge CLK);
			BUS_VALID <= 1'b1;
			BUS_WORD  <= bus_word;
			@(posedge CLK);
			BUS_VALID <= 1'b0;
			BUS_WORD  <= ~bus_word;
		end
	end
endmodule

/* File: prs_sequencer_tb_top.sv */
module prs_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LOCK_BASE = 16;

	logic        clk     = 1'b0;
	logic        reset_n = 1'b0;
	logic [3:0]  ref_div = 4'h1;
	logic        por_short;
	logic        hard_out;
	logic        soft_out;
	logic [3:0]  ratio   = 4'h4;
	logic [1:0]  tsel    = 2'h0;
	logic        por_n;
	logic [13:0] straps;
	logic        hv;
	logic [31:0] hw;
	logic        bv;
	logic [31:0] bw;
	logic        fetch;
	logic        hard_oe;
	logic        soft_oe;
	logic        ipor_n;
	logic        lock;
	logic [31:0] cfg;
	logic        cfg_def;
	logic [13:0] lat;
	logic [3:0]  den;
	logic [3:0]  t2;
	logic [3:0]  t3;
	logic [3:0]  t4;
	logic [3:0]  upos;
	logic [3:0]  spos;
	logic        unsup;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc       = 0;

	always #4 clk = ~clk;

	prs_partner u_partner
	(
		.CLK(clk), .BUS_CFG_FETCH_REQ(fetch), .POR_N(por_n), .STRAPS(straps),
		.HOST_VALID(hv), .HOST_WORD(hw), .BUS_VALID(bv), .BUS_WORD(bw)
	);

	prs_sequencer #(.PLL_LOCK_BASE(LOCK_BASE)) DUT
	(
		.CLK(clk), .RESET_N(reset_n), .POWER_ON_RESET_IN_N(por_n),
		.CONFIG_MODE_STRAP(straps[0]), .CONFIG_SOURCE_STRAP(straps[1]),
		.HOST_SYNC_STRAP(straps[2]), .HOST_WIDE_STRAP(straps[3]),
		.CHIP_SELECT_ID_STRAPS(straps[7:4]), .BOOT_MODE_STRAPS(straps[10:8]),
		.WATCHDOG_ENABLE_STRAP(straps[11]), .CLOCK_MODE_STRAPS(straps[13:12]),
		.HARD_RESET_LINE_OUT(hard_out), .HARD_RESET_LINE_OE(hard_oe),
		.SOFT_RESET_LINE_OUT(soft_out), .SOFT_RESET_LINE_OE(soft_oe),
		.HOST_CFG_VALID(hv), .HOST_CFG_WORD(hw), .BUS_CFG_VALID(bv),
		.BUS_CFG_WORD(bw), .BUS_CFG_FETCH_REQ(fetch), .REFERENCE_DIVISION_FACTOR(ref_div),
		.CORE_CLOCK_RATIO(ratio), .MC_TICK_SELECT(tsel), .INTERNAL_POR_N(ipor_n),
		.SYSTEM_PLL_LOCK(lock), .POR_PULSE_SHORT(por_short), .CONFIG_WORD(cfg),
		.CONFIG_WORD_DEFAULTED(cfg_def), .LATCHED_CONFIG_MODE(lat[0]),
		.LATCHED_CONFIG_SOURCE(lat[1]), .LATCHED_HOST_SYNC(lat[2]),
		.LATCHED_HOST_WIDE(lat[3]), .LATCHED_CHIP_ID(lat[7:4]),
		.LATCHED_BOOT_MODE(lat[10:8]), .LATCHED_WATCHDOG_ENABLE(lat[11]),
		.LATCHED_CLOCK_MODE(lat[13:12]), .TICK_DENOM(den), .TICK2_POS(t2),
		.TICK3_POS(t3), .TICK4_POS(t4), .USER_MACHINE_TICK_POS(upos),
		.SDRAM_MACHINE_TICK_POS(spos), .RATIO_UNSUPPORTED(unsup)
	);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask

	// Outputs are sampled on the falling edge, away from the launching edge.
	task automatic wait_lvl(ref logic sig, input logic lvl);
		int n;
		n = 0;
		while (sig !== lvl && n < 4000)
		begin
			@(negedge clk);
			n++;
		end
		chk_flag(sig, lvl);
		@(posedge clk);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_ticks();
		logic [3:0] r [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'h7};
		logic [3:0] d;
		logic [3:0] a;
		logic [3:0] b;
		logic [3:0] p;
		foreach (r[i])
			for (int k = 0; k < 4; k++)
			begin
				@(posedge clk);
				ratio <= r[i];
				tsel  <= k[1:0];
				repeat (2) @(negedge clk);
				d = (r[i] == 4'h3) ? 4'h6 : (r[i] == 4'h5) ? 4'hA : 4'h4;
				a = (r[i] == 4'h5) ? 4'h2 : 4'h1;
				b = (r[i] == 4'h3) ? 4'h4 : (r[i] == 4'h5) ? 4'h7 : 4'h3;
				p = (k == 0) ? 4'h0 : (k == 1) ? a : (k == 2) ? (d >> 1) : b;
				chk_word({7'h0, den, t2, t3, t4, upos, spos, unsup},
					{7'h0, d, a, d >> 1, b, p, 4'h0, r[i] == 4'h7});
			end
		$display("tick plan test done");
	endtask

	task automatic t_host();
		@(posedge clk);
		ref_div <= 4'h2;
		u_partner.por_pulse(16, 14'h2B68);
		u_partner.send_host(32'h11111111);
		wait_lvl(ipor_n, 1'b1);
		u_partner.send_host(32'h3C5A0F96);
		u_partner.send_host(32'h00007777);
		wait_lvl(soft_oe, 1'b0);
		chk_word(cfg, 32'h3C5A0F96);
		chk_flag(cfg_def, 1'b0);
		chk_word({18'h0, lat}, {18'h0, 14'h2B68});
		chk_flag(hard_oe, 1'b0);
		chk_flag(lock, 1'b1);
		chk_flag(por_short, 1'b0);
		chk_word({30'h0, hard_out, soft_out}, 32'h00000000);
		$display("host config test done");
	endtask

	task automatic t_master();
		u_partner.bus_delay = 300;
		u_partner.bus_word  = 32'h9E3779B9;
		u_partner.por_pulse(16, 14'h1C93);
		wait_lvl(ipor_n, 1'b1);
		u_partner.por_pulse(16, 14'h1C93);
		@(negedge clk);
		chk_flag(hard_oe, 1'b1);
		chk_flag(soft_oe, 1'b1);
		chk_flag(ipor_n, 1'b0);
		wait_lvl(soft_oe, 1'b0);
		chk_word(cfg, 32'h9E3779B9);
		chk_word({18'h0, lat}, {18'h0, 14'h1C93});
		chk_flag(por_short, 1'b0);
		$display("bus master test done");
	endtask

	task automatic t_slave();
		@(posedge clk);
		ref_div <= 4'h0;
		u_partner.por_pulse(20, 14'h0402);
		wait_lvl(ipor_n, 1'b1);
		u_partner.send_host(32'h0BADF00D);
		wait_lvl(soft_oe, 1'b0);
		chk_word(cfg, prs_pkg::CFG_WORD_DEFAULT);
		chk_flag(cfg_def, 1'b1);
		$display("bus slave default test done");
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			complete_run();
		end
	end

	initial
	begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		t_ticks();
		t_host();
		t_master();
		t_slave();
		complete_run();
	end
endmodule
